// file: pawg_pkg.sv
// Shared constants and types for the peripheral access wait generator.
`default_nettype none

package pawg_pkg;

   // ********************************************************************
   // Access kinds
   // ********************************************************************
   typedef enum logic [2:0]
   {
      PAWG_KIND_MODE_WR = 3'b000,
      PAWG_KIND_CHSEL_WR = 3'b001,
      PAWG_KIND_PORTCFG_WR = 3'b010,
      PAWG_KIND_RESULT_RD = 3'b011,
      PAWG_KIND_BUFRAM_WR = 3'b100,
      PAWG_KIND_PLAIN = 3'b111
   } pawg_kind_t;

   // ********************************************************************
   // Widths and wait formula constants
   // ********************************************************************
   localparam int PAWG_KIND_W = 3;
   localparam int PAWG_DIV_W = 4;
   localparam int PAWG_RATIO_W = 8;
   localparam int PAWG_RATIO_FRAC = 4;
   localparam int PAWG_PROD_W = 13;
   localparam int PAWG_CNT_W = 10;
   localparam logic [PAWG_PROD_W-1:0] PAWG_CONV_PERIODS = 13'h0002;
   localparam logic [PAWG_PROD_W-1:0] PAWG_BUF_PERIODS = 13'h0005;
   localparam logic [PAWG_CNT_W-1:0] PAWG_WAIT_EXTRA = 10'h001;
   localparam logic [PAWG_CNT_W-1:0] PAWG_RESULT_MIN_WAIT = 10'h002;
   localparam logic [PAWG_RATIO_FRAC-1:0] PAWG_LOW_WIDTH_FRAC = 4'h8;
   localparam logic [PAWG_PROD_W-1:0] PAWG_BASE_MULT_FULL = 13'h0001;
   localparam logic [PAWG_PROD_W-1:0] PAWG_BASE_MULT_HALF = 13'h0002;
   localparam int PAWG_QUIET_W = 3;
   localparam logic [PAWG_QUIET_W-1:0] PAWG_SER_QUIET_CLKS = 3'h5;
   localparam logic [PAWG_QUIET_W-1:0] PAWG_QUIET_RESET = 3'h0;
   localparam logic [PAWG_CNT_W-1:0] PAWG_CNT_RESET = 10'h000;
   localparam logic [PAWG_CNT_W-1:0] PAWG_CNT_LAST = 10'h001;

endpackage

`default_nettype wire

// file: pawg_cnt_if.sv
// Interface between the wait generator control and its stall counter.
`default_nettype none

interface pawg_cnt_if;
   import pawg_pkg::*;

   logic load;
   logic [PAWG_CNT_W-1:0] count;
   logic busy;
   logic done;

   modport ctrl
   (
      output load,
      output count,
      input busy,
      input done
   );

   modport counter
   (
      input load,
      input count,
      output busy,
      output done
   );
endinterface

`default_nettype wire

// file: pawg_wait_counter.sv
// Stall counter that holds busy for the loaded number of CPU clocks.
`default_nettype none

module pawg_wait_counter
(
   input wire logic clk,
   input wire logic rst,
   pawg_cnt_if.counter bus
);
   import pawg_pkg::*;

   logic [PAWG_CNT_W-1:0] cnt_q;
   logic busy_q;
   logic done_q;

   assign bus.busy = busy_q;
   assign bus.done = done_q;

   // ********************************************************************
   // Down counter
   // ********************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_q <= PAWG_CNT_RESET;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (bus.load && !busy_q)
         begin
            if (bus.count == PAWG_CNT_RESET)
            begin
               done_q <= 1'b1;
            end
            else
            begin
               busy_q <= 1'b1; // RQ15
               cnt_q <= bus.count;
            end
         end
         else if (busy_q)
         begin
            cnt_q <= cnt_q - PAWG_CNT_LAST; // RQ7
            if (cnt_q == PAWG_CNT_LAST)
            begin
               busy_q <= 1'b0; // RQ15
               done_q <= 1'b1; // RQ15
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: pawg_wait_gen.sv
// Top of the peripheral access wait generator between CPU bus and peripheral bus.
//
// What this block does
// RQ1: Channel-select write stalls 1 to 7 clocks.
// RQ2: Port-config write stalls 1 to 9 clocks.
// RQ3: Result read stalls 2-13, 2-17 or 2-25 clocks.
// RQ4: Converter wait is two converter periods plus one.
// RQ5: Fastest CPU clock yields the largest converter wait.
// RQ6: Software avoids stalling accesses with peripheral clock stopped.
// RQ7: All waits count in CPU clock periods.
// RQ8: Buffer RAM write stalls 1 to 81 clocks.
// RQ9: Buffer wait is five serial periods plus one.
// RQ10: Buffer fraction truncated up to low width, else rounded.
// RQ11: Serial base clock is full or half peripheral.
// RQ12: No buffer wait after five quiet serial clocks.
// RQ13: Hold next instruction until data crossed safely.
// RQ14: Mode write stalls 1 to 5 clocks.
// RQ15: Wait held exactly computed clocks, completion on release.
`default_nettype none

module pawg_wait_gen
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic ACC_VALID,
   input wire pawg_pkg::pawg_kind_t ACC_KIND,
   input wire logic [pawg_pkg::PAWG_DIV_W-1:0] CONV_CLK_DIV,
   input wire logic [pawg_pkg::PAWG_RATIO_W-1:0] CPU_PER_PRS_RATIO,
   input wire logic SERIAL_BASE_CLK_SEL,
   input wire logic SER_UNIT_RAM_WR,
   input wire logic SER_UNIT_CLK,
   output logic CPU_WAIT,
   output logic ACC_DONE
);
   import pawg_pkg::*;

   // ********************************************************************
   // Declarations
   // ********************************************************************
   pawg_cnt_if cnt_bus ();

   logic wr_sync1_q;
   logic wr_sync2_q;
   logic wr_last_q;
   logic sck_sync1_q;
   logic sck_sync2_q;
   logic sck_last_q;
   logic [PAWG_QUIET_W-1:0] quiet_q;
   logic [PAWG_QUIET_W-1:0] quiet_d;
   logic load_q;
   logic [PAWG_CNT_W-1:0] count_q;
   logic [PAWG_CNT_W-1:0] count_d;

   logic wr_rise;
   logic sck_rise;
   logic ser_quiet;
   logic take;
   logic is_mode_wr;
   logic is_chsel_wr;
   logic is_portcfg_wr;
   logic is_result_rd;
   logic is_bufram_wr;
   logic is_conv;
   logic [PAWG_PROD_W-1:0] conv_prod;
   logic [PAWG_CNT_W-1:0] conv_wait;
   logic [PAWG_CNT_W-1:0] result_wait;
   logic [PAWG_PROD_W-1:0] base_mult;
   logic [PAWG_PROD_W-1:0] buf_prod;
   logic [PAWG_RATIO_FRAC-1:0] buf_frac;
   logic buf_round_up;
   logic [PAWG_CNT_W-1:0] buf_int;
   logic [PAWG_CNT_W-1:0] buf_wait;

   // ********************************************************************
   // Serial unit activity crossing
   // ********************************************************************
   // Both serial signals come from the peripheral clock domain, so only the
   // second stage of each synchroniser feeds the edge detectors.
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         wr_sync1_q <= 1'b0;
         wr_sync2_q <= 1'b0;
         wr_last_q <= 1'b0;
         sck_sync1_q <= 1'b0;
         sck_sync2_q <= 1'b0;
         sck_last_q <= 1'b0;
      end
      else
      begin
         wr_sync1_q <= SER_UNIT_RAM_WR;
         wr_sync2_q <= wr_sync1_q;
         wr_last_q <= wr_sync2_q;
         sck_sync1_q <= SER_UNIT_CLK;
         sck_sync2_q <= sck_sync1_q;
         sck_last_q <= sck_sync2_q;
      end
   end

   assign wr_rise = wr_sync2_q && !wr_last_q;
   assign sck_rise = sck_sync2_q && !sck_last_q;

   // ********************************************************************
   // Serial quiet counter
   // ********************************************************************
   // A serial write in the same cycle as a serial clock edge restarts the
   // count, so a fresh serial write is never missed.
   always_comb
   begin
      quiet_d = quiet_q;
      if (wr_rise)
      begin
         quiet_d = PAWG_QUIET_RESET; // RQ12
      end
      else if (sck_rise && (quiet_q != PAWG_SER_QUIET_CLKS))
      begin
         quiet_d = quiet_q + 3'h1; // RQ12
      end
   end

   assign ser_quiet = (quiet_q == PAWG_SER_QUIET_CLKS); // RQ12

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         quiet_q <= PAWG_QUIET_RESET;
      end
      else
      begin
         quiet_q <= quiet_d;
      end
   end

   // ********************************************************************
   // Access decode
   // ********************************************************************
   // A request still held on the done cycle belongs to the access that just ended,
   // so it is not taken a second time.
   assign take = ACC_VALID && !cnt_bus.busy && !load_q && !cnt_bus.done; // RQ13
   assign is_mode_wr = (ACC_KIND == PAWG_KIND_MODE_WR); // RQ14
   assign is_chsel_wr = (ACC_KIND == PAWG_KIND_CHSEL_WR); // RQ1
   assign is_portcfg_wr = (ACC_KIND == PAWG_KIND_PORTCFG_WR); // RQ2
   assign is_result_rd = (ACC_KIND == PAWG_KIND_RESULT_RD); // RQ3
   assign is_bufram_wr = (ACC_KIND == PAWG_KIND_BUFRAM_WR); // RQ8
   assign is_conv = is_mode_wr || is_chsel_wr || is_portcfg_wr;

   // ********************************************************************
   // Converter wait count
   // ********************************************************************
   // The ratio is CPU clocks per peripheral clock period in fixed point, so a
   // faster CPU raises the product and the wait with it.
   assign conv_prod = PAWG_CONV_PERIODS * PAWG_PROD_W'(CONV_CLK_DIV)
                    * PAWG_PROD_W'(CPU_PER_PRS_RATIO); // RQ4 RQ5
   assign conv_wait = PAWG_CNT_W'(conv_prod[PAWG_PROD_W-1:PAWG_RATIO_FRAC])
                    + PAWG_WAIT_EXTRA; // RQ4
   assign result_wait = (conv_wait < PAWG_RESULT_MIN_WAIT) ? PAWG_RESULT_MIN_WAIT
                      : conv_wait; // RQ3

   // ********************************************************************
   // Buffer RAM wait count
   // ********************************************************************
   assign base_mult = SERIAL_BASE_CLK_SEL ? PAWG_BASE_MULT_HALF
                    : PAWG_BASE_MULT_FULL; // RQ11
   assign buf_prod = PAWG_BUF_PERIODS * base_mult
                   * PAWG_PROD_W'(CPU_PER_PRS_RATIO); // RQ9
   assign buf_frac = buf_prod[PAWG_RATIO_FRAC-1:0];
   // The low-level width is taken as half a CPU period; a clock with another
   // duty cycle would need a different threshold.
   assign buf_round_up = (buf_frac > PAWG_LOW_WIDTH_FRAC); // RQ10
   assign buf_int = PAWG_CNT_W'(buf_prod[PAWG_PROD_W-1:PAWG_RATIO_FRAC]);
   assign buf_wait = buf_int + PAWG_CNT_W'(buf_round_up) + PAWG_WAIT_EXTRA; // RQ9 RQ8

   // ********************************************************************
   // Wait selection
   // ********************************************************************
   always_comb
   begin
      count_d = PAWG_CNT_RESET;
      if (is_conv)
      begin
         count_d = conv_wait; // RQ1 RQ2 RQ14
      end
      else if (is_result_rd)
      begin
         count_d = result_wait; // RQ3
      end
      else if (is_bufram_wr && !ser_quiet)
      begin
         count_d = buf_wait; // RQ8 RQ12
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         load_q <= 1'b0;
         count_q <= PAWG_CNT_RESET;
      end
      else
      begin
         load_q <= take;
         if (take)
         begin
            count_q <= count_d;
         end
      end
   end

   // ********************************************************************
   // Stall counter
   // ********************************************************************
   assign cnt_bus.load = load_q;
   assign cnt_bus.count = count_q;

   pawg_wait_counter u_counter
   (
      .clk(CLOCK),
      .rst(SYS_RST),
      .bus(cnt_bus.counter)
   );

   assign CPU_WAIT = cnt_bus.busy; // RQ13 RQ15
   assign ACC_DONE = cnt_bus.done; // RQ15

endmodule

`default_nettype wire

// file: pawg_wait_gen_properties.sv
// Port checker for the peripheral access wait generator.
`default_nettype none
module pawg_wait_gen_properties
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic ACC_VALID,
   input wire pawg_pkg::pawg_kind_t ACC_KIND,
   input wire logic [pawg_pkg::PAWG_DIV_W-1:0] CONV_CLK_DIV,
   input wire logic [pawg_pkg::PAWG_RATIO_W-1:0] CPU_PER_PRS_RATIO,
   input wire logic SERIAL_BASE_CLK_SEL,
   input wire logic SER_UNIT_RAM_WR,
   input wire logic SER_UNIT_CLK,
   input wire logic CPU_WAIT,
   input wire logic ACC_DONE
);
   timeunit 1ns;
   timeprecision 1ps;
   import pawg_pkg::*;
   logic taken_q;
   wire take = ACC_VALID && !CPU_WAIT && !taken_q && !ACC_DONE;
   wire unity = CPU_PER_PRS_RATIO == 8'h10;
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
         taken_q <= 1'b0;
      else
         taken_q <= take;
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   chk_done_on_fall:
      assert property ($fell(CPU_WAIT) |-> ACC_DONE) else $error("Wait fell without done.");
   chk_done_pulse_once:
      assert property (ACC_DONE |=> !ACC_DONE) else $error("Done held too long.");
   chk_wait_has_cause:
      assert property ($rose(CPU_WAIT) |-> $past(taken_q)) else $error("Wait without access.");
   chk_plain_no_wait:
      assert property (take && ACC_KIND == PAWG_KIND_PLAIN |-> ##2 ACC_DONE && !CPU_WAIT)
         else $error("Plain access stalled.");
   chk_chsel_seven:
      assert property (take && ACC_KIND == PAWG_KIND_CHSEL_WR && CONV_CLK_DIV == 4'h3 && unity
         |-> ##2 CPU_WAIT [*7] ##1 ACC_DONE && !CPU_WAIT) else $error("Channel wait wrong.");
   chk_mode_five:
      assert property (take && ACC_KIND == PAWG_KIND_MODE_WR && CONV_CLK_DIV == 4'h2 && unity
         |-> ##2 CPU_WAIT [*5] ##1 ACC_DONE && !CPU_WAIT) else $error("Mode wait wrong.");
   chk_portcfg_nine:
      assert property (take && ACC_KIND == PAWG_KIND_PORTCFG_WR && CONV_CLK_DIV == 4'h4 && unity
         |-> ##2 CPU_WAIT ##8 CPU_WAIT ##1 ACC_DONE) else $error("Port wait wrong.");
   chk_result_thirteen:
      assert property (take && ACC_KIND == PAWG_KIND_RESULT_RD && CONV_CLK_DIV == 4'h6 && unity
         |-> ##2 CPU_WAIT ##12 CPU_WAIT ##1 ACC_DONE) else $error("Result wait wrong.");
   chk_buf_half_trunc:
      assert property (take && ACC_KIND == PAWG_KIND_BUFRAM_WR && !SERIAL_BASE_CLK_SEL
         && CPU_PER_PRS_RATIO == 8'h18 |-> ##2 CPU_WAIT [*8] ##1 ACC_DONE)
         else $error("Buffer wait wrong.");
   cover property (take && ACC_KIND == PAWG_KIND_BUFRAM_WR);
   cover property ($fell(CPU_WAIT));
   cover property (take && ACC_KIND == PAWG_KIND_PLAIN);
endmodule
`default_nettype wire

// file: pawg_cpu_model.sv
// CPU core model that issues one access at a time.
`default_nettype none
module pawg_cpu_model
(
   input wire logic clk,
   input wire logic acc_done,
   output logic acc_valid,
   output pawg_pkg::pawg_kind_t acc_kind
);
   timeunit 1ns;
   timeprecision 1ps;
   import pawg_pkg::*;
   initial
   begin
      acc_valid = 1'b0;
      acc_kind = PAWG_KIND_PLAIN;
   end
   // The request is held until done is seen, then dropped; the generator ignores it then.
   task automatic issue(input pawg_kind_t kind, output bit hung);
      int n;
      n = 0;
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_kind <= kind;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (acc_done !== 1'b1 && n < 400);
      acc_valid <= 1'b0;
      acc_kind <= PAWG_KIND_PLAIN;
      hung = (acc_done !== 1'b1);
   endtask
endmodule
`default_nettype wire

// file: pawg_wait_gen_tb.sv
// Self-checking testbench for the peripheral access wait generator.
`default_nettype none
module pawg_wait_gen_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pawg_pkg::*;
   logic CLOCK = 1'b0;
   logic SYS_RST = 1'b1;
   logic ACC_VALID;
   pawg_kind_t ACC_KIND;
   logic [PAWG_DIV_W-1:0] CONV_CLK_DIV = 4'h2;
   logic [PAWG_RATIO_W-1:0] CPU_PER_PRS_RATIO = 8'h10;
   logic SERIAL_BASE_CLK_SEL = 1'b0;
   logic SER_UNIT_RAM_WR = 1'b0;
   logic SER_UNIT_CLK = 1'b0;
   logic CPU_WAIT;
   logic ACC_DONE;
   int bad_count = 0;
   int num_checks = 0;
   int wait_cnt = 0;
   integer seed = 79;
   int exp_q[$];
   bit hung;
   pawg_kind_t kinds[6] = '{PAWG_KIND_MODE_WR, PAWG_KIND_CHSEL_WR, PAWG_KIND_PORTCFG_WR,
      PAWG_KIND_RESULT_RD, PAWG_KIND_BUFRAM_WR, PAWG_KIND_PLAIN};
   always #50 CLOCK = ~CLOCK;
   pawg_wait_gen i_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ACC_VALID(ACC_VALID),
      .ACC_KIND(ACC_KIND), .CONV_CLK_DIV(CONV_CLK_DIV), .CPU_PER_PRS_RATIO(CPU_PER_PRS_RATIO),
      .SERIAL_BASE_CLK_SEL(SERIAL_BASE_CLK_SEL), .SER_UNIT_RAM_WR(SER_UNIT_RAM_WR),
      .SER_UNIT_CLK(SER_UNIT_CLK), .CPU_WAIT(CPU_WAIT), .ACC_DONE(ACC_DONE));
   pawg_cpu_model i_cpu (.clk(CLOCK), .acc_done(ACC_DONE), .acc_valid(ACC_VALID),
      .acc_kind(ACC_KIND));
   function automatic int exp_wait(pawg_kind_t k, int n, int r, int s);
      int c;
      int p;
      c = 2 * n * r / 16 + 1;
      p = 5 * (s + 1) * r;
      case (k)
         PAWG_KIND_MODE_WR, PAWG_KIND_CHSEL_WR, PAWG_KIND_PORTCFG_WR: return c;
         PAWG_KIND_RESULT_RD: return (c < 2) ? 2 : c;
         PAWG_KIND_BUFRAM_WR: return p / 16 + ((p % 16) > 8) + 1;
         default: return 0;
      endcase
   endfunction
   task automatic compare_wait(int exp, int got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected wait clocks: expected %0d seen %0d", exp, got);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic run(pawg_kind_t k, int n, int r, int s, int quiet);
      @(posedge CLOCK);
      CONV_CLK_DIV <= n[PAWG_DIV_W-1:0];
      CPU_PER_PRS_RATIO <= r[PAWG_RATIO_W-1:0];
      SERIAL_BASE_CLK_SEL <= s[0];
      exp_q.push_back(quiet ? 0 : exp_wait(k, n, r, s));
      i_cpu.issue(k, hung);
      compare_wait(0, hung);
   endtask
   task automatic ser_pulses(int cnt, int ram);
      repeat (cnt)
      begin
         @(posedge CLOCK);
         SER_UNIT_CLK <= 1'b1;
         SER_UNIT_RAM_WR <= ram[0];
         repeat (2) @(posedge CLOCK);
         SER_UNIT_CLK <= 1'b0;
         SER_UNIT_RAM_WR <= 1'b0;
         repeat (2) @(posedge CLOCK);
      end
      repeat (6) @(posedge CLOCK);
   endtask
   // Each done pulse closes one access; the count of stall cycles before it is compared.
   always @(posedge CLOCK)
   begin
      if (SYS_RST)
         wait_cnt = 0;
      else if (ACC_DONE === 1'b1)
      begin
         compare_wait(exp_q.size() ? exp_q.pop_front() : -1, wait_cnt);
         wait_cnt = 0;
      end
      else if (CPU_WAIT === 1'b1)
         wait_cnt++;
   end
   initial
   begin
      repeat (2) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      run(PAWG_KIND_MODE_WR, 2, 16, 0, 0);
      run(PAWG_KIND_CHSEL_WR, 3, 16, 0, 0);
      run(PAWG_KIND_PORTCFG_WR, 4, 16, 0, 0);
      run(PAWG_KIND_RESULT_RD, 6, 16, 0, 0);
      run(PAWG_KIND_RESULT_RD, 8, 16, 0, 0);
      run(PAWG_KIND_RESULT_RD, 12, 16, 0, 0);
      run(PAWG_KIND_RESULT_RD, 2, 2, 0, 0);
      run(PAWG_KIND_CHSEL_WR, 3, 32, 0, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 16, 0, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 16, 1, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 128, 1, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 24, 0, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 19, 0, 0);
      run(PAWG_KIND_PLAIN, 2, 16, 0, 0);
      repeat (10)
         run(kinds[$unsigned($random(seed)) % 6], 2 + $unsigned($random(seed)) % 11,
            4 + $unsigned($random(seed)) % 125, $random(seed) & 1, 0);
      ser_pulses(6, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 16, 0, 1);
      ser_pulses(1, 1);
      ser_pulses(4, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 16, 0, 0);
      ser_pulses(1, 0);
      run(PAWG_KIND_BUFRAM_WR, 2, 16, 0, 1);
      @(posedge CLOCK);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      run(PAWG_KIND_BUFRAM_WR, 2, 16, 0, 0);
      repeat (4) @(posedge CLOCK);
      compare_wait(0, exp_q.size());
      close_out();
   end
   initial
   begin
      #3000000;
      bad_count++;
      close_out();
   end
endmodule
bind pawg_wait_gen pawg_wait_gen_properties i_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
   .ACC_VALID(ACC_VALID), .ACC_KIND(ACC_KIND), .CONV_CLK_DIV(CONV_CLK_DIV),
   .CPU_PER_PRS_RATIO(CPU_PER_PRS_RATIO), .SERIAL_BASE_CLK_SEL(SERIAL_BASE_CLK_SEL),
   .SER_UNIT_RAM_WR(SER_UNIT_RAM_WR), .SER_UNIT_CLK(SER_UNIT_CLK), .CPU_WAIT(CPU_WAIT),
   .ACC_DONE(ACC_DONE));
`default_nettype wire
